// *** rtl/vrc_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// Operation
// - writing one to control bit 7 turns the reference on, zero keeps it off.
// - the ready flag at bit 6 is set by hardware only after settling and ignores writes.
// - ready stays low for a settling interval after enable rather than rising at once.
// - two gain stages each pick 1x, 2x or 4x independently of the other.
// - bits 1-0 set the converter gain, 11 is 4x, 10 is 2x, 01 is 1x.
// - bits 3-2 set the comparator, dac and sensing gain with the same coding.
module vrc_top
  import vrc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire vrc_pkg::vrc_apb_req_t apb_req,
  output vrc_pkg::vrc_apb_rsp_t apb_rsp,
  output logic reference_enable,
  output logic reference_ready,
  output logic temp_indicator_enable,
  output logic temp_indicator_range,
  output vrc_pkg::vrc_amp_t converter_amp,
  output vrc_pkg::vrc_amp_t cmp_dac_sense_amp
);
  import vrc_pkg::*;

  typedef struct packed {
    logic [7:0] control;
    logic ready;
    logic [15:0] settle_len;
    logic [15:0] count;
    vrc_apb_rsp_t rsp;
    vrc_amp_t adc_amp;
    vrc_amp_t cds_amp;
  } vrc_state_t;

  vrc_state_t state_ff;
  vrc_state_t nxt_state;
  vrc_amp_t adc_dec;
  vrc_amp_t cds_dec;
  logic setup_acc;
  logic wr_acc;
  logic rd_acc;
  logic ctl_wr;
  logic addr_hit;
  logic [7:0] ctl_view;
  logic [7:0] nxt_ctl;

  vrc_gain_decode u_adc_dec (
    .code(nxt_ctl[VRC_BIT_ADC_HI:VRC_BIT_ADC_LO]),
    .amp(adc_dec)
  );
  vrc_gain_decode u_cds_dec (
    .code(nxt_ctl[VRC_BIT_CDS_HI:VRC_BIT_CDS_LO]),
    .amp(cds_dec)
  );

  // zero-wait slave: setup then access always completes
  assign setup_acc = apb_req.psel & ~apb_req.penable;
  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_acc = setup_acc & ~apb_req.pwrite;
  assign ctl_wr = wr_acc & (apb_req.paddr == VRC_ADDR_CONTROL);
  assign addr_hit = (apb_req.paddr == VRC_ADDR_CONTROL) | (apb_req.paddr == VRC_ADDR_STATUS) |
    (apb_req.paddr == VRC_ADDR_SETTLE);

  // next control kept apart so the decoders do not loop through nxt_state
  always_comb begin
    ctl_view = state_ff.control;
    ctl_view[VRC_BIT_READY] = state_ff.ready;
    nxt_ctl = state_ff.control;
    if (ctl_wr) begin
      nxt_ctl = apb_req.pwdata[7:0];
      nxt_ctl[VRC_BIT_READY] = 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rsp.pready = 1'b1;
    nxt_state.control = nxt_ctl;
    // error decided at setup so it stands beside pready in access
    if (setup_acc) begin
      nxt_state.rsp.pslverr = ~addr_hit;
    end
    if (wr_acc && (apb_req.paddr == VRC_ADDR_SETTLE)) begin
      nxt_state.settle_len = apb_req.pwdata[15:0];
    end
    // read data prepared during setup, stable through access
    if (rd_acc) begin
      case (apb_req.paddr)
        VRC_ADDR_CONTROL: nxt_state.rsp.prdata = {24'h000000, ctl_view};
        VRC_ADDR_STATUS: nxt_state.rsp.prdata = {16'h0000, state_ff.count};
        VRC_ADDR_SETTLE: nxt_state.rsp.prdata = {16'h0000, state_ff.settle_len};
        default: nxt_state.rsp.prdata = VRC_RDATA_ZERO;
      endcase
    end
    if (!nxt_state.control[VRC_BIT_ENABLE]) begin
      nxt_state.ready = 1'b0;
      nxt_state.count = VRC_CNT_ZERO;
    end else if (!state_ff.control[VRC_BIT_ENABLE]) begin
      // fresh enable reloads the settle timer; zero length still waits one cycle
      nxt_state.ready = 1'b0;
      nxt_state.count = (state_ff.settle_len == VRC_CNT_ZERO) ? VRC_CNT_ONE : state_ff.settle_len;
    end else if (state_ff.count > VRC_CNT_ONE) begin
      nxt_state.count = state_ff.count - VRC_CNT_ONE;
    end else if (state_ff.count == VRC_CNT_ONE) begin
      nxt_state.count = VRC_CNT_ZERO;
      nxt_state.ready = 1'b1;
    end
    nxt_state.adc_amp = adc_dec;
    nxt_state.cds_amp = cds_dec;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
      state_ff.control <= VRC_CONTROL_RESET;
      state_ff.settle_len <= VRC_SETTLE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs are flops; pready held high so every access takes two cycles
  assign apb_rsp = state_ff.rsp;
  assign reference_enable = state_ff.control[VRC_BIT_ENABLE];
  assign reference_ready = state_ff.ready;
  assign temp_indicator_enable = state_ff.control[VRC_BIT_TEMP_EN];
  assign temp_indicator_range = state_ff.control[VRC_BIT_TEMP_RNG];
  assign converter_amp = state_ff.adc_amp;
  assign cmp_dac_sense_amp = state_ff.cds_amp;
endmodule
`default_nettype wire

// *** rtl/vrc_pkg.sv ***
package vrc_pkg;
  // register map (byte addresses on the apb word grid)
  localparam logic [11:0] VRC_ADDR_CONTROL = 12'h000;
  localparam logic [11:0] VRC_ADDR_STATUS = 12'h004;
  localparam logic [11:0] VRC_ADDR_SETTLE = 12'h008;
  // control field positions
  localparam int VRC_BIT_ENABLE = 7;
  localparam int VRC_BIT_READY = 6;
  localparam int VRC_BIT_TEMP_EN = 5;
  localparam int VRC_BIT_TEMP_RNG = 4;
  localparam int VRC_BIT_CDS_HI = 3;
  localparam int VRC_BIT_CDS_LO = 2;
  localparam int VRC_BIT_ADC_HI = 1;
  localparam int VRC_BIT_ADC_LO = 0;
  localparam logic [7:0] VRC_CONTROL_RESET = 8'h00;
  // settle time in microseconds, and its cycle count at 50 MHz
  localparam int VRC_CLK_MHZ = 50;
  localparam int VRC_SETTLE_US = 25;
  localparam int VRC_SETTLE_CYCLES = VRC_SETTLE_US * VRC_CLK_MHZ;
  localparam logic [15:0] VRC_SETTLE_RESET = 16'(VRC_SETTLE_CYCLES);
  localparam logic [15:0] VRC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] VRC_CNT_ONE = 16'h0001;
  localparam logic [31:0] VRC_RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    VRC_GAIN_OFF = 2'b00,
    VRC_GAIN_X1 = 2'b01,
    VRC_GAIN_X2 = 2'b10,
    VRC_GAIN_X4 = 2'b11
  } vrc_gain_t;

  // one amplifier's decoded drive
  typedef struct packed {
    logic on;
    logic x1;
    logic x2;
    logic x4;
  } vrc_amp_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } vrc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } vrc_apb_rsp_t;
endpackage

// *** rtl/vrc_gain_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module vrc_gain_decode
  import vrc_pkg::*;
(
  input wire logic [1:0] code,
  output var vrc_pkg::vrc_amp_t amp
);
  import vrc_pkg::*;

  always_comb begin
    amp = '0;
    case (vrc_gain_t'(code))
      VRC_GAIN_OFF: amp = '0;
      VRC_GAIN_X1: begin
        amp.on = 1'b1;
        amp.x1 = 1'b1;
      end
      VRC_GAIN_X2: begin
        amp.on = 1'b1;
        amp.x2 = 1'b1;
      end
      VRC_GAIN_X4: begin
        amp.on = 1'b1;
        amp.x4 = 1'b1;
      end
      default: amp = '0;
    endcase
  end
endmodule
`default_nettype wire

// *** test/vrc_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module vrc_asserts
  import vrc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire vrc_pkg::vrc_apb_req_t apb_req,
  input wire logic reference_enable,
  input wire logic reference_ready,
  input wire vrc_pkg::vrc_amp_t converter_amp,
  input wire vrc_pkg::vrc_amp_t cmp_dac_sense_amp
);
  function automatic vrc_amp_t dec(input logic [1:0] c);
    return (c == 2'b00) ? 4'h0 : {1'b1, c == 2'b01, c == 2'b10, c == 2'b11};
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_wr;
    apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == VRC_ADDR_CONTROL;
  endsequence
  a_enable_write: assert property (s_wr |=> reference_enable == $past(apb_req.pwdata[7]))
    else $error("enable bit not applied");
  a_ready_early: assert property ($rose(reference_enable) |-> !reference_ready)
    else $error("ready at enable");
  a_ready_off: assert property (!reference_enable && !$past(reference_enable) |-> !reference_ready)
    else $error("ready while off");
  a_conv_gain: assert property (s_wr |=> converter_amp == dec($past(apb_req.pwdata[1:0])))
    else $error("converter gain wrong");
  a_cds_gain: assert property (s_wr |=> cmp_dac_sense_amp == dec($past(apb_req.pwdata[3:2])))
    else $error("cmp gain wrong");
  a_amp_hold: assert property (!(apb_req.psel && apb_req.pwrite) |=> $stable({converter_amp, cmp_dac_sense_amp}))
    else $error("gain moved without write");
  a_amp_onehot: assert property (converter_amp.on |-> $onehot({converter_amp.x1, converter_amp.x2, converter_amp.x4}))
    else $error("gain not one of three");
  a_off_quiet: assert property (!cmp_dac_sense_amp.on |-> cmp_dac_sense_amp == 4'h0)
    else $error("off stage drives gain");
  a_ready_needs_en: assert property (reference_ready |-> reference_enable)
    else $error("ready without enable");
endmodule
bind vrc_top vrc_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn), .apb_req(apb_req),
  .reference_enable(reference_enable), .reference_ready(reference_ready),
  .converter_amp(converter_amp), .cmp_dac_sense_amp(cmp_dac_sense_amp));
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import vrc_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  vrc_apb_req_t req = '0;
  vrc_apb_rsp_t rsp;
  logic ren, rdy;
  vrc_amp_t camp, damp;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] rv;
  logic se;
  logic [3:0] tab [4] = '{4'h0, 4'hc, 4'ha, 4'h9};
  vrc_top DUT (.clk_sys(clk_sys), .resetn(resetn), .apb_req(req), .apb_rsp(rsp), .reference_enable(ren),
    .reference_ready(rdy), .temp_indicator_enable(), .temp_indicator_range(), .converter_amp(camp),
    .cmp_dac_sense_amp(damp));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one setup plus access; an idle edge after keeps strobes clean
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.pready !== 1'b1);
    rv = rsp.prdata;
    se = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  // outputs settle by the falling edge
  task automatic look(input logic [9:0] e);
    @(negedge clk_sys);
    chk({22'h0, ren, rdy, camp, damp}, {22'h0, e});
    @(posedge clk_sys);
  endtask
  task automatic end_of_test;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(VRC_ADDR_CONTROL, 32'h0);
    rd(VRC_ADDR_SETTLE, {16'h0, VRC_SETTLE_RESET});
    // short settle keeps the run brief
    apb(1'b1, VRC_ADDR_SETTLE, 32'h8);
    apb(1'b1, VRC_ADDR_CONTROL, 32'hff);
    look(10'b10_1001_1001);
    rd(VRC_ADDR_CONTROL, 32'hbf);
    repeat (12) @(posedge clk_sys);
    rd(VRC_ADDR_CONTROL, 32'hff);
    rd(VRC_ADDR_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, VRC_ADDR_CONTROL, {28'h0, 2'(i), 2'(3 - i)});
      look({2'b00, tab[3 - i], tab[i]});
    end
    rd(12'hffc, 32'h0);
    chk({31'h0, se}, 32'h1);
    rd(VRC_ADDR_CONTROL, 32'h0c);
    chk({31'h0, se}, 32'h0);
    // second reset in mid-run must clear the control bits again
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    look(10'h0);
    rd(VRC_ADDR_CONTROL, 32'h0);
    rd(VRC_ADDR_SETTLE, {16'h0, VRC_SETTLE_RESET});
    end_of_test();
  end
endmodule
`default_nettype wire
